// [edge_detect.sv]
// Edge detector for the four external pin lines with selectable polarity.
// Assumes pin levels already synchronous to clk.
`timescale 1ns/1ps
module edge_detect
   import irq_sel_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       clk_en,
   input  wire logic [3:0] pin_level,
   input  wire logic [3:0] polarity,
   output logic      [3:0] pin_edge
);
   logic [3:0] prev_reg;
   logic [3:0] edge_reg;

   // Polarity 0 takes rising edges, 1 takes falling edges
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_reg <= 4'h0;
         edge_reg <= 4'h0;
      end else if (clk_en) begin
         prev_reg <= pin_level;
         edge_reg <= (pin_level ^ polarity) & ~(prev_reg ^ polarity);
      end
   end

   assign pin_edge = edge_reg;
endmodule

// [event_source_model.sv]
// Peripheral event sources and interrupt-capable pins.
// Assumes pins already enabled and set as inputs.
`timescale 1ns/1ps
module event_source_model
   import irq_sel_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       fire,
   input  wire logic [4:0] code,
   output source_events_t  events,
   output logic      [3:0] pin_level
);
   logic [$bits(source_events_t)-1:0] vec;
   initial events = '0;
   initial pin_level = 4'h0;
   // ---------
   // Sources
   // ---------
   always @(posedge clk) begin
      vec = '0;
      if (fire && code >= 1 && code <= 16 && !(code inside {[4:7]}))
         vec[code - 1] = 1'b1;
      events <= source_events_t'(vec);
      // One-cycle high pin: a rise then a fall, driven as an input
      pin_level <= (fire && code inside {[4:7]}) ? 4'h1 << (code - 4) : 4'h0;
   end
endmodule

// [interrupt_source_selector.sv]
// Interrupt source selector: routes event sources onto sixteen core lines.
// Assumes synchronous single-cycle event inputs and a plain register port.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`include "irq_sel_cfg.svh"
module interrupt_source_selector
   import irq_sel_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           sys_rst,
   input  wire logic           clk_en,
   input  wire logic           reset_request,
   input  wire logic           nmi_request,
   input  wire logic [3:0]     external_pin_line_4,
   input  wire source_events_t events,
   input  wire logic [31:0]    reg_addr,
   input  wire logic [31:0]    reg_wdata,
   input  wire logic           reg_wr,
   input  wire logic           reg_rd,
   output logic      [31:0]    reg_rdata,
   output logic      [15:0]    core_irq,
   output logic                irq_out
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [31:0] interrupt_select_high_reg;
   logic [31:0] interrupt_select_low_reg;
   logic [3:0]  edge_polarity_bits_reg;
   logic [15:0] status_reg;
   logic [15:0] mask_reg;
   logic [31:0] rdata_reg;
   logic [15:0] core_irq_reg;
   logic [15:0] core_irq_next;
   logic [3:0]  pin_edge;
   logic [31:0] rdata_next;
   reg_req_t    req;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic sel_code_t field_of(input logic [31:0] r, input int unsigned idx);
      sel_code_t f;
      f = '0;
      case (idx)
         0: f = r[`SEL_FIELD_LSB0 +: `SEL_FIELD_W];
         1: f = r[`SEL_FIELD_LSB1 +: `SEL_FIELD_W];
         2: f = r[`SEL_FIELD_LSB2 +: `SEL_FIELD_W];
         3: f = r[`SEL_FIELD_LSB3 +: `SEL_FIELD_W];
         4: f = r[`SEL_FIELD_LSB4 +: `SEL_FIELD_W];
         5: f = r[`SEL_FIELD_LSB5 +: `SEL_FIELD_W];
         default: f = '0;
      endcase
      return f;
   endfunction

   // Decodes a selector code into the chosen event
   function automatic logic route(input sel_code_t code, input source_events_t ev,
                                  input logic [3:0] pe);
      logic hit;
      hit = 1'b0;
      case (code)
         5'h00: hit = 1'b0;
         5'h01: hit = ev.timer_zero_event;
         5'h02: hit = ev.timer_one_event;
         5'h03: hit = ev.sdram_refresh_timer_event;
         5'h04: hit = pe[0];
         5'h05: hit = pe[1];
         5'h06: hit = pe[2];
         5'h07: hit = pe[3];
         5'h08: hit = ev.dma_completion_event;
         5'h09: hit = ev.emulation_data_dma_event;
         5'h0A: hit = ev.emulation_receive_event;
         5'h0B: hit = ev.emulation_transmit_event;
         5'h0C: hit = ev.serial0_transmit_event;
         5'h0D: hit = ev.serial0_receive_event;
         5'h0E: hit = ev.serial1_transmit_event;
         5'h0F: hit = ev.serial1_receive_event;
         5'h10: hit = ev.pin_event_0;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // ----------------------------------------
   // Pin edge detection
   // ----------------------------------------
   edge_detect u_edge (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .pin_level (external_pin_line_4),
      .polarity  (edge_polarity_bits_reg),
      .pin_edge  (pin_edge)
   );

   // ----------------------------------------
   // Selector and polarity registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         interrupt_select_low_reg  <= `RST_SELECT_LOW;
         interrupt_select_high_reg <= `RST_SELECT_HIGH;
         edge_polarity_bits_reg    <= `RST_POLARITY;
      end else if (clk_en && req.wr) begin
         case (req.addr)
            `ADDR_SELECT_HIGH: interrupt_select_high_reg <= req.wdata & `SEL_WRITE_MASK;
            `ADDR_SELECT_LOW:  interrupt_select_low_reg  <= req.wdata & `SEL_WRITE_MASK;
            `ADDR_POLARITY:    edge_polarity_bits_reg    <= req.wdata[3:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Line routing
   // ----------------------------------------
   // Registered so each source pulse lands as exactly one cycle on its line
   always_comb begin
      core_irq_next    = '0;
      core_irq_next[0] = reset_request;
      core_irq_next[1] = nmi_request;
      for (int i = 0; i < 6; i++) begin
         core_irq_next[4 + i]  = route(field_of(interrupt_select_low_reg, i), events, pin_edge);
         core_irq_next[10 + i] = route(field_of(interrupt_select_high_reg, i), events, pin_edge);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         core_irq_reg <= 16'h0000;
      end else if (clk_en) begin
         core_irq_reg <= core_irq_next;
      end
   end

   assign core_irq = core_irq_reg;

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_reg <= 16'h0000;
      end else if (clk_en) begin
         // New events win over a write-one clear in the same cycle
         if (req.wr && req.addr == `ADDR_IRQ_STATUS) begin
            status_reg <= (status_reg & ~req.wdata[15:0]) | core_irq_reg;
         end else begin
            status_reg <= status_reg | core_irq_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mask_reg <= `RST_IRQ_MASK;
      end else if (clk_en && req.wr && req.addr == `ADDR_IRQ_MASK) begin
         mask_reg <= req.wdata[15:0];
      end
   end

   assign irq_out = |(status_reg & mask_reg);

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      case (req.addr)
         `ADDR_SELECT_HIGH: rdata_next = interrupt_select_high_reg;
         `ADDR_SELECT_LOW:  rdata_next = interrupt_select_low_reg;
         `ADDR_POLARITY:    rdata_next = {28'h000_0000, edge_polarity_bits_reg};
         `ADDR_IRQ_STATUS:  rdata_next = {16'h0000, status_reg};
         `ADDR_IRQ_MASK:    rdata_next = {16'h0000, mask_reg};
         default:           rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         rdata_reg <= req.rd ? rdata_next : 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_reg;
endmodule

// [interrupt_source_selector_test.sv]
// Bench: registers, routing, status and mask of the selector.
// Assumes design, package, event model and checker alongside.
`timescale 1ns/1ps
module interrupt_source_selector_test
   import irq_sel_pkg::*;
;
   logic           clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, fire = 1'b0;
   logic           reset_request = 1'b0, nmi_request = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [4:0]     code = '0;
   logic [31:0]    reg_addr = '0, reg_wdata = '0, reg_rdata, lo, hi, rv;
   logic [15:0]    core_irq;
   logic [3:0]     pins;
   logic           irq_out;
   source_events_t events;
   int             mismatches = 0, compares = 0, pol = 0;
   interrupt_source_selector u_interrupt_source_selector (.clk(clk), .sys_rst(sys_rst),
      .clk_en(clk_en), .reset_request(reset_request), .nmi_request(nmi_request),
      .external_pin_line_4(pins), .events(events), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_irq(core_irq), .irq_out(irq_out));
   event_source_model u_event_source_model (.clk(clk), .fire(fire), .code(code),
      .events(events), .pin_level(pins));
   // ---------
   // Helpers
   // ---------
   task automatic check(input string name, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [31:0] a, d);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   function automatic int fld(input logic [31:0] l, h, input int n);
      int i;
      i = (n - 4) % 6;
      return ((n < 10 ? l : h) >> (i * 5 + (i > 2))) & 31;
   endfunction
   function automatic logic [31:0] pack(input int a, b, c, d, e, f);
      int k[6];
      k = '{a, b, c, d, e, f};
      pack = '0;
      for (int i = 0; i < 6; i++) pack |= 32'(k[i]) << (i * 5 + (i > 2));
   endfunction
   function automatic logic [31:0] pick(input int it);
      return it == 0 ? 32'hFFFF_FFFF : it == 1 ? 32'h4210_4210 : $urandom();
   endfunction
   // Pins take one more cycle, falling polarity one more again
   task automatic send(input int s);
      logic [15:0] v;
      v = '0;
      for (int n = 4; n < 16; n++) v[n] = s >= 1 && s <= 16 && fld(lo, hi, n) == s;
      @(posedge clk);
      {fire, code} <= {1'b1, 5'(s)};
      @(posedge clk);
      fire <= 1'b0;
      repeat (s >= 4 && s <= 7 ? 2 + pol : 1) @(posedge clk);
      #1 check("core_irq", 32'(core_irq), 32'(v));
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial forever #5 clk = ~clk;
   initial begin
      #500_000;
      mismatches++;
      give_verdict();
   end
   initial begin
      void'($urandom(99));
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      lo = pack(4, 5, 6, 7, 8, 9);
      hi = pack(3, 10, 11, 0, 1, 2);
      rd(32'h019C_0004);
      check("select_low", rv, lo);
      rd(32'h019C_0000);
      check("select_high", rv, hi);
      rd(32'h019C_0014);
      check("unmapped", rv, '0);
      wr(32'h019C_0010, 32'h0000_4000);
      send(1);
      rd(32'h019C_000C);
      check("status", rv, 32'h0000_4000);
      check("irq_out", 32'(irq_out), 32'h1);
      wr(32'h019C_0010, '0);
      check("irq_out", 32'(irq_out), '0);
      wr(32'h019C_000C, 32'h0000_4000);
      wr(32'h019C_0010, 32'h0000_4000);
      check("irq_out", 32'(irq_out), '0);
      @(posedge clk);
      {reset_request, nmi_request} <= 2'b11;
      @(posedge clk);
      {reset_request, nmi_request} <= 2'b00;
      #1 check("fixed_lines", 32'(core_irq[3:0]), 32'h3);
      // Write with the clock enable low must not land
      @(posedge clk) clk_en <= 1'b0;
      wr(32'h019C_0004, '0);
      @(posedge clk) clk_en <= 1'b1;
      rd(32'h019C_0004);
      check("select_low_frozen", rv, lo);
      for (int it = 0; it < 40; it++) begin
         wr(32'h019C_0004, pick(it));
         lo = reg_wdata & 32'h7FFF_7FFF;
         wr(32'h019C_0000, pick(it));
         hi = reg_wdata & 32'h7FFF_7FFF;
         rd(32'h019C_0004);
         check("select_low", rv, lo);
         rd(32'h019C_0000);
         check("select_high", rv, hi);
         if (it == 20) begin
            wr(32'h019C_0008, 32'h0000_000F);
            pol = 1;
         end
         for (int s = 0; s < 18; s++) send(s);
      end
      give_verdict();
   end
endmodule

// [irq_sel_cfg.svh]
// Constants of the interrupt source selector: offsets, field positions, resets.
// Assumes inclusion by the package and by the design modules only.
//
// Overview of operation
// - Sixteen prioritized core lines; line 0 is reset and highest, line 15 lowest.
// - Lines 0-3 are fixed, non-maskable: reset, NMI, two reserved lines; mask bits 0-1 still gate reset and NMI status into irq_out.
// - Lines 4-15 are maskable, each chosen by its own 5-bit selector field.
// - High selector at 0x019C0000, low selector at 0x019C0004, twelve fields together.
// - Low register fields for lines 4-9 at 4:0,9:5,14:10,20:16,25:21,30:26.
// - High register fields for lines 10-15 use the same layout.
// - Lines 4-9 reset to 00100,00101,00110,00111,01000,01001.
// - Lines 10-15 reset to 00011,01010,01011,00000,00001,00010.
// - Value 0 is no event, 1 timer 0, 2 timer 1, 3 SDRAM timer.
// - Values 4-7 pin events 4-7, 8 DMA completion, 9-11 emulation events.
// - Values 12-15 serial 0/1 transmit and receive, 16 pin event 0.
// - Pin events 4-7 are edge-sensitive, edge chosen by four polarity bits.
`ifndef IRQ_SEL_CFG_SVH
`define IRQ_SEL_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_SELECT_HIGH   32'h019C_0000
`define ADDR_SELECT_LOW    32'h019C_0004
`define ADDR_POLARITY      32'h019C_0008
`define ADDR_IRQ_STATUS    32'h019C_000C
`define ADDR_IRQ_MASK      32'h019C_0010

// ----------------------------------------
// Field layout
// ----------------------------------------
`define SEL_FIELD_W        5
`define SEL_FIELD_LSB0     0
`define SEL_FIELD_LSB1     5
`define SEL_FIELD_LSB2     10
`define SEL_FIELD_LSB3     16
`define SEL_FIELD_LSB4     21
`define SEL_FIELD_LSB5     26
`define SEL_WRITE_MASK     32'h7FFF_7FFF

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SELECT_LOW     32'h2507_18A4
`define RST_SELECT_HIGH    32'h0820_2D43
`define RST_POLARITY       4'h0
`define RST_IRQ_MASK       16'h0000

`endif

// [irq_sel_pkg.sv]
// Types shared by the interrupt source selector modules.
// Assumes irq_sel_cfg.svh sits in the same folder.
package irq_sel_pkg;
`include "irq_sel_cfg.svh"

   typedef logic [`SEL_FIELD_W-1:0] sel_code_t;

   // Source events as they arrive, one bit each
   typedef struct packed {
      logic pin_event_0;
      logic serial1_receive_event;
      logic serial1_transmit_event;
      logic serial0_receive_event;
      logic serial0_transmit_event;
      logic emulation_transmit_event;
      logic emulation_receive_event;
      logic emulation_data_dma_event;
      logic dma_completion_event;
      logic [3:0] pin_event_4_7;
      logic sdram_refresh_timer_event;
      logic timer_one_event;
      logic timer_zero_event;
   } source_events_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage

// [irq_sel_sva.sv]
// Port checker for the interrupt source selector.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module irq_sel_sva
   import irq_sel_pkg::*;
(
   input wire logic           clk,
   input wire logic           sys_rst,
   input wire logic           clk_en,
   input wire logic           reset_request,
   input wire logic           nmi_request,
   input wire logic [3:0]     external_pin_line_4,
   input wire source_events_t events,
   input wire logic [31:0]    reg_addr,
   input wire logic [31:0]    reg_wdata,
   input wire logic           reg_wr,
   input wire logic           reg_rd,
   input wire logic [31:0]    reg_rdata,
   input wire logic [15:0]    core_irq,
   input wire logic           irq_out
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ---------
   // Checks
   // ---------
   // Three idle samples outlast the two-cycle pin path
   sequence quiet_s;
      (events == '0 && !reg_wr && $stable(external_pin_line_4)) [*3];
   endsequence
   AST_LINE0: assert property (clk_en && reset_request |=> core_irq[0])
      else $error("line 0 not raised");
   AST_LINE1: assert property (clk_en && nmi_request |=> core_irq[1])
      else $error("line 1 not raised");
   AST_FIXED: assert property (core_irq[3:2] == 2'b00)
      else $error("reserved line active");
   AST_QUIET: assert property (quiet_s |=> core_irq[15:4] == '0)
      else $error("line active with no event");
   AST_RD_IDLE: assert property (clk_en && !reg_rd |=> reg_rdata == '0)
      else $error("read data outside read");
   AST_UNMAPPED: assert property (reg_rd && reg_addr > 32'h019C_0010 |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   AST_SEL_RSVD: assert property (reg_rd && reg_addr[31:3] == 29'h0033_8000
      |=> !reg_rdata[15] && !reg_rdata[31]) else $error("selector spare bit set");
   AST_UNMASK: assert property (reg_wr && reg_addr == 32'h019C_0010 && reg_wdata == '0
      |=> !irq_out) else $error("interrupt with empty mask");
endmodule
bind interrupt_source_selector irq_sel_sva u_irq_sel_sva (.clk(clk), .sys_rst(sys_rst),
   .clk_en(clk_en), .reset_request(reset_request), .nmi_request(nmi_request),
   .external_pin_line_4(external_pin_line_4), .events(events), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .core_irq(core_irq), .irq_out(irq_out));
